// ==== pkg/fps_pkg.sv ====
// Shared constants, types and register map of the flash protect block.
package fps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map, byte offsets from the block base.
    localparam logic [11:0] SEC_REG_OFS = 12'h010;
    localparam logic [11:0] STAT_REG_OFS = 12'h014;
    localparam int ADDR_DEC_W = 12;

    // Security register fields.
    localparam int SEC_BIT_POS = 0;
    localparam logic SEC_BIT_RST = 1'b1;
    localparam logic [31:0] UNLOCK_KEY = 32'hA74A9D23;
    localparam logic [4:0] UNLOCK_WIN_CYC = 5'h10;

    // Status register fields.
    localparam int RDY_POS = 0;
    localparam int PROT_POS = 16;
    localparam logic RDY_RST = 1'b1;

    // Protect bit geometry.
    localparam int NUM_BLOCKS = 6;
    localparam int GROUP_SIZE = 4;
    localparam int BLK_IDX_W = 3;
    localparam logic [NUM_BLOCKS-1:0] PROT_RST = 6'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_PERIOD_NS = 20;
    localparam int RST_MIN_NS = 500;
    localparam int RST_MIN_CYC =
        (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 5;
    localparam int READ_DELAY_MS = 2;
    localparam int READ_DELAY_CYC = READ_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RD_CNT_W = 17;

    ////////////////////////////////////////////////////////////////////////
    // Bus encodings.
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_PAGE_PROG = 3'h1,
        OP_BLOCK_ERASE = 3'h2,
        OP_CHIP_ERASE = 3'h3,
        OP_PROT_PROG = 3'h4,
        OP_PROT_ERASE = 3'h5
    } fps_op_t;

    typedef enum logic [1:0] {
        FSM_READY = 2'h0,
        FSM_BUSY = 2'h1,
        FSM_FAIL = 2'h3
    } fps_fsm_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_SEC = 2'h1,
        SEL_STAT = 2'h2
    } fps_sel_t;

    // Command request from the command sequencer.
    typedef struct packed {
        logic valid;
        fps_op_t op;
        logic [BLK_IDX_W-1:0] block;
    } fps_cmd_t;

    // Start of an automatic operation towards the flash engine.
    typedef struct packed {
        logic start;
        fps_op_t op;
        logic [BLK_IDX_W-1:0] block;
    } fps_start_t;

endpackage : fps_pkg

// ==== verilog/fps_protect_store.sv ====
// Protect bit cells: loaded from the array after reset, then updated.
`timescale 1ns/100ps
module fps_protect_store
    import fps_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [NUM_BLOCKS-1:0] nv_protect_bits,
    input wire logic set_en,
    input wire logic [BLK_IDX_W-1:0] set_idx,
    input wire logic clr_grp_en,
    input wire logic [BLK_IDX_W-1:0] clr_blk,
    input wire logic clr_all,
    output logic loaded,
    output logic [NUM_BLOCKS-1:0] block_protect_bits
);

    typedef struct packed {
        logic loaded;
        logic [NUM_BLOCKS-1:0] bits;
    } fps_store_t;

    fps_store_t s_q;
    fps_store_t s_d;

    always_comb begin
        s_d = s_q;
        if (!s_q.loaded) begin
            s_d.bits = nv_protect_bits;
            s_d.loaded = 1'b1;
        end else begin
            for (int i = 0; i < NUM_BLOCKS; i++) begin
                if (clr_all) begin
                    s_d.bits[i] = 1'b0;
                end else if (clr_grp_en &&
                        (i / GROUP_SIZE) == (int'(clr_blk) / GROUP_SIZE)) begin
                    // Erase clears the whole group: cells 0-3, or the two cells 4-5.
                    s_d.bits[i] = 1'b0;
                end else if (set_en && int'(set_idx) == i) begin
                    s_d.bits[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '{loaded: 1'b0, bits: PROT_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign loaded = s_q.loaded;
    assign block_protect_bits = s_q.bits;

endmodule : fps_protect_store

// ==== verilog/fps_top.sv ====
// Flash protect and security control with its register slave.
//
// How it works
// - Protect program sets that block's protect bit.
// - Protect erase clears protect bits, cancelling protection.
// - Program one bit; erase groups of four (blocks 4-5 form a group of two).
// - Six read-only status bits, one means protected.
// - Reprogramming a protected block is refused.
// - Secured only when security and all protects set.
// - Secured device still allows ordinary flash reads.
// - Secured device disables the whole debug port.
// - Secured device refuses command writes to array.
// - Secured protect erase becomes full chip erase.
// - Cold reset forces the security bit to one.
// - Busy during automatic operation, ready when done.
// - Failed operation stays busy until hardware reset.
// - Reset held 0.5 us; readable 2 ms later.
// - After reset load protect status, ready is one.
// - Security register reads zero except bit zero.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module fps_top
    import fps_pkg::*;
#(
    parameter int unsigned READ_DELAY = READ_DELAY_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic warm_resetn,
    input wire logic [NUM_BLOCKS-1:0] nv_protect_bits,
    input wire fps_cmd_t cmd,
    output logic cmd_accept,
    output logic cmd_refused,
    output fps_start_t op_start,
    input wire logic op_done,
    input wire logic op_fail,
    output logic ready_busy_flag,
    output logic secured,
    output logic debug_enable,
    output logic array_read_enable,
    output logic array_readable
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        fps_fsm_t fsm;
        logic clr_all_pend;
        fps_start_t start;
        logic sec_bit;
        logic [4:0] unlock_cnt;
        logic ap_valid;
        logic ap_write;
        logic ap_word;
        fps_sel_t ap_sel;
        logic [31:0] rdata;
        logic [RST_CNT_W-1:0] wlow_cnt;
        logic [RD_CNT_W-1:0] rd_cnt;
        logic readable;
        logic secured;
    } fps_state_t;

    localparam fps_state_t STATE_RST = '{
        fsm: FSM_READY,
        clr_all_pend: 1'b0,
        start: '{start: 1'b0, op: OP_NONE, block: '0},
        sec_bit: SEC_BIT_RST,
        unlock_cnt: '0,
        ap_valid: 1'b0,
        ap_write: 1'b0,
        ap_word: 1'b0,
        ap_sel: SEL_NONE,
        rdata: '0,
        wlow_cnt: '0,
        rd_cnt: '0,
        readable: 1'b0,
        secured: 1'b0
    };

    fps_state_t s_q;
    fps_state_t s_d;

    logic [NUM_BLOCKS-1:0] block_protect_bits;
    logic store_loaded;
    logic st_set;
    logic [BLK_IDX_W-1:0] st_blk;
    logic st_clr_grp;
    logic st_clr_all;
    logic secure_now;
    logic warm_fire;

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic fps_sel_t fps_decode(input logic [31:0] addr);
        fps_sel_t sel;
        sel = SEL_NONE;
        if (addr[ADDR_DEC_W-1:0] == SEC_REG_OFS) begin
            sel = SEL_SEC;
        end else if (addr[ADDR_DEC_W-1:0] == STAT_REG_OFS) begin
            sel = SEL_STAT;
        end
        return sel;
    endfunction : fps_decode

    // Any other offset reads zero and ignores writes.
    function automatic logic [31:0] fps_read(
        input fps_sel_t sel,
        input fps_state_t st,
        input logic [NUM_BLOCKS-1:0] prot
    );
        logic [31:0] v;
        v = '0;
        case (sel)
            SEL_SEC: begin
                v[SEC_BIT_POS] = st.sec_bit;
            end
            SEL_STAT: begin
                v[RDY_POS] = (st.fsm == FSM_READY);
                v[PROT_POS +: NUM_BLOCKS] = prot;
            end
            default: begin
                v = '0;
            end
        endcase
        return v;
    endfunction : fps_read

    ////////////////////////////////////////////////////////////////////////
    // Protect bit cells.

    fps_protect_store fps_protect_store_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .nv_protect_bits(nv_protect_bits),
        .set_en(st_set),
        .set_idx(st_blk),
        .clr_grp_en(st_clr_grp),
        .clr_blk(st_blk),
        .clr_all(st_clr_all),
        .loaded(store_loaded),
        .block_protect_bits(block_protect_bits)
    );

    assign secure_now = s_q.sec_bit & (&block_protect_bits)
        & store_loaded;

    // A warm reset only counts once it has been held long enough.
    assign warm_fire = warm_resetn &&
        (s_q.wlow_cnt == RST_CNT_W'(RST_MIN_CYC));

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        s_d = s_q;
        cmd_accept = 1'b0;
        cmd_refused = 1'b0;
        st_set = 1'b0;
        st_clr_grp = 1'b0;
        st_clr_all = 1'b0;
        st_blk = s_q.start.block;
        s_d.start.start = 1'b0;
        s_d.secured = secure_now;

        // Register slave: capture the address phase.
        s_d.ap_valid = hsel && hready && htrans[1];
        s_d.ap_write = hwrite;
        s_d.ap_word = (hsize == HSIZE_WORD);
        s_d.ap_sel = fps_decode(haddr);
        if (hsel && hready && htrans[1] && !hwrite) begin
            s_d.rdata = fps_read(fps_decode(haddr), s_q, block_protect_bits);
        end

        // Security register unlock window.
        if (s_q.unlock_cnt != '0) begin
            s_d.unlock_cnt = s_q.unlock_cnt - 5'h01;
        end
        if (s_q.ap_valid && s_q.ap_write && s_q.ap_sel == SEL_SEC) begin
            if (s_q.ap_word && hwdata == UNLOCK_KEY) begin
                s_d.unlock_cnt = UNLOCK_WIN_CYC;
            end else if (s_q.ap_word && s_q.unlock_cnt != '0) begin
                s_d.sec_bit = hwdata[SEC_BIT_POS];
                s_d.unlock_cnt = '0;
            end
            // Otherwise the write is dropped silently.
        end

        // Command acceptance and automatic operation tracking.
        case (s_q.fsm)
            FSM_READY: begin
                if (cmd.valid) begin
                    cmd_accept = 1'b1;
                    s_d.start = '{start: 1'b1, op: cmd.op, block: cmd.block};
                    s_d.clr_all_pend = 1'b0;
                    if (secure_now) begin
                        if (cmd.op == OP_PROT_ERASE) begin
                            s_d.start.op = OP_CHIP_ERASE;
                            s_d.clr_all_pend = 1'b1;
                        end else begin
                            cmd_accept = 1'b0;
                        end
                    end else begin
                        case (cmd.op)
                            OP_PAGE_PROG, OP_BLOCK_ERASE: begin
                                if (block_protect_bits[cmd.block]) begin
                                    cmd_accept = 1'b0;
                                end
                            end
                            OP_CHIP_ERASE, OP_PROT_PROG: begin
                                cmd_accept = 1'b1;
                            end
                            OP_PROT_ERASE: begin
                                cmd_accept = 1'b1;
                            end
                            default: begin
                                cmd_accept = 1'b0;
                            end
                        endcase
                        if (int'(cmd.block) >= NUM_BLOCKS &&
                                cmd.op != OP_CHIP_ERASE) begin
                            cmd_accept = 1'b0;
                        end
                    end
                    cmd_refused = !cmd_accept;
                    if (cmd_accept) begin
                        s_d.fsm = FSM_BUSY;
                    end else begin
                        s_d.start = s_q.start;
                        s_d.start.start = 1'b0;
                    end
                end
            end
            FSM_BUSY: begin
                // Commands issued while busy are dropped.
                cmd_refused = cmd.valid;
                if (op_done) begin
                    if (op_fail) begin
                        s_d.fsm = FSM_FAIL;
                    end else begin
                        s_d.fsm = FSM_READY;
                        if (s_q.clr_all_pend) begin
                            st_clr_all = 1'b1;
                        end else if (s_q.start.op == OP_PROT_PROG) begin
                            st_set = 1'b1;
                        end else if (s_q.start.op == OP_PROT_ERASE) begin
                            st_clr_grp = 1'b1;
                        end
                    end
                end
            end
            FSM_FAIL: begin
                cmd_refused = cmd.valid;
            end
            default: begin
                s_d.fsm = FSM_READY;
            end
        endcase

        // Read-back delay after any reset.
        if (!s_q.readable) begin
            if (32'(s_q.rd_cnt) >= READ_DELAY - 1) begin
                s_d.readable = 1'b1;
            end else begin
                s_d.rd_cnt = s_q.rd_cnt + 1'b1;
            end
        end

        // Warm reset length qualification.
        if (!warm_resetn) begin
            if (s_q.wlow_cnt != RST_CNT_W'(RST_MIN_CYC)) begin
                s_d.wlow_cnt = s_q.wlow_cnt + 1'b1;
            end
        end else begin
            s_d.wlow_cnt = '0;
        end

        // A qualified warm reset aborts the operation and the unlock window, restarts the read-back delay; it keeps the protect bits and the security bit,
        // which only the cold reset restores.
        if (warm_fire) begin
            s_d.fsm = FSM_READY;
            s_d.start.start = 1'b0;
            s_d.clr_all_pend = 1'b0;
            s_d.unlock_cnt = '0;
            s_d.rd_cnt = '0;
            s_d.readable = 1'b0;
            st_set = 1'b0;
            st_clr_grp = 1'b0;
            st_clr_all = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Zero wait states: every access completes in its first data cycle.
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = s_q.rdata;
    assign op_start = s_q.start;
    assign ready_busy_flag = (s_q.fsm == FSM_READY);
    assign secured = s_q.secured;
    assign debug_enable = !s_q.secured;
    // Reads are never blocked by security, only by the read-back delay.
    assign array_read_enable = 1'b1;
    assign array_readable = s_q.readable;

endmodule : fps_top

// ==== bench/fps_top_assertions.sv ====
// Port-level checks for the flash protect block.
`timescale 1ns/100ps
module fps_top_assertions
    import fps_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic warm_resetn,
    input wire fps_cmd_t cmd,
    input wire logic cmd_accept,
    input wire logic cmd_refused,
    input wire fps_start_t op_start,
    input wire logic op_done,
    input wire logic op_fail,
    input wire logic ready_busy_flag,
    input wire logic secured,
    input wire logic debug_enable,
    input wire logic array_read_enable
);
    logic rd_sec_q;
    logic rd_stat_q;
    logic rd_take;

    assign rd_take = hsel && hready && htrans[1] && !hwrite;

    // Marks the data phase of a read, where the registered hrdata stands.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_sec_q <= 1'b0;
            rd_stat_q <= 1'b0;
        end else begin
            rd_sec_q <= rd_take && haddr[11:0] == SEC_REG_OFS;
            rd_stat_q <= rd_take && haddr[11:0] == STAT_REG_OFS;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    chk_debug_gate: assert property (
        secured |-> ##[0:1] !debug_enable)
        else $error("debug port open while secured");
    chk_secured_nocmd: assert property (secured && cmd.valid &&
        cmd.op != OP_PROT_ERASE |-> !cmd_accept)
        else $error("command taken while secured");
    chk_chip_convert: assert property (cmd_accept && secured &&
        cmd.op == OP_PROT_ERASE |=> op_start.start &&
        op_start.op == OP_CHIP_ERASE)
        else $error("secured protect erase not turned into chip erase");
    chk_start_busy: assert property (cmd_accept |=>
        op_start.start && !ready_busy_flag)
        else $error("accepted command did not start and go busy");
    chk_busy_refuse: assert property (
        !ready_busy_flag && cmd.valid |-> cmd_refused && !cmd_accept)
        else $error("command taken while busy");
    chk_fail_hold: assert property (
        op_done && op_fail && warm_resetn |=> !ready_busy_flag [*4])
        else $error("ready returned after a failed operation");
    chk_sec_read: assert property (
        rd_sec_q |-> hrdata[31:1] == 31'h0)
        else $error("security register upper bits not zero");
    chk_stat_read: assert property (rd_stat_q |->
        hrdata[31:22] == 10'h0 && hrdata[15:1] == 15'h0)
        else $error("status register reserved bits not zero");
    chk_array_read: assert property (array_read_enable)
        else $error("array reads blocked");

    cover property (cmd_accept && secured);
    cover property (op_done && op_fail);
    cover property (rd_sec_q && hrdata[0] == 1'b0);
endmodule : fps_top_assertions

bind fps_top fps_top_assertions fps_top_assertions_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .warm_resetn(warm_resetn), .cmd(cmd), .cmd_accept(cmd_accept),
    .cmd_refused(cmd_refused), .op_start(op_start), .op_done(op_done),
    .op_fail(op_fail), .ready_busy_flag(ready_busy_flag),
    .secured(secured), .debug_enable(debug_enable),
    .array_read_enable(array_read_enable)
);

// ==== bench/fps_engine_model.sv ====
// Behavioural flash engine answering each started operation.
`timescale 1ns/100ps
module fps_engine_model
    import fps_pkg::*;
#(
    parameter int DELAY = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire fps_start_t op_start,
    input wire logic fail_req,
    output logic op_done,
    output logic op_fail
);
    int cnt;

    // One completion per start; the fail flag only means something with done.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            op_done <= 1'b0;
            op_fail <= 1'b0;
        end else begin
            op_done <= cnt == 1;
            op_fail <= cnt == 1 && fail_req;
            if (op_start.start) begin
                cnt <= DELAY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : fps_engine_model

// ==== bench/flash_protect_security_bench.sv ====
// Self-checking bench for the flash protect block.
`timescale 1ns/100ps
module flash_protect_security_bench
    import fps_pkg::*;
;
    localparam int RD_DLY = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic warm_resetn = 1'b1;
    logic [5:0] nv_bits = 6'h00;
    fps_cmd_t cmd = '0;
    logic fail_req = 1'b0;
    logic hreadyout, hresp, cmd_accept, cmd_refused, op_done, op_fail;
    logic [31:0] hrdata, d;
    fps_start_t op_start;
    logic rdy, secured, debug_enable, ar_en, readable;
    logic [5:0] exp_prot;
    logic exp_sec = 1'b1;
    logic exp_rdy = 1'b1;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 32'h0A21;

    always #10 hclk = ~hclk;

    fps_top #(.READ_DELAY(RD_DLY)) fps_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .warm_resetn(warm_resetn),
        .nv_protect_bits(nv_bits), .cmd(cmd), .cmd_accept(cmd_accept),
        .cmd_refused(cmd_refused), .op_start(op_start), .op_done(op_done),
        .op_fail(op_fail), .ready_busy_flag(rdy), .secured(secured),
        .debug_enable(debug_enable), .array_read_enable(ar_en),
        .array_readable(readable)
    );

    fps_engine_model #(.DELAY(8)) fps_engine_model_i (
        .hclk(hclk), .hresetn(hresetn), .op_start(op_start),
        .fail_req(fail_req), .op_done(op_done), .op_fail(op_fail)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_flag(string nm, logic e, logic g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_flag

    // Single word transfer; read data is taken at the data phase edge.
    task automatic bus(logic wr, logic [11:0] ofs, logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h00000, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk_flag("hresp", HRESP_OKAY, hresp);
    endtask : bus

    task automatic check_state;
        logic sec;
        sec = exp_sec && exp_prot == 6'h3F;
        bus(1'b0, STAT_REG_OFS, 32'h0, d);
        chk_word("status", {10'h0, exp_prot, 15'h0, exp_rdy}, d);
        bus(1'b0, SEC_REG_OFS, 32'h0, d);
        chk_word("security", {31'h0, exp_sec}, d);
        chk_flag("secured", sec, secured);
        chk_flag("debug", !sec, debug_enable);
        chk_flag("ready", exp_rdy, rdy);
    endtask : check_state

    // Issues one command, a second one while busy if the first was accepted, and updates the model.
    task automatic do_cmd(logic [2:0] op, logic [2:0] blk, logic fail);
        logic sec, acc, ok;
        int n;
        sec = exp_sec && exp_prot == 6'h3F;
        ok = blk < 3'h6;
        case (op)
            3'h1, 3'h2: acc = ok && !exp_prot[blk] && !sec;
            3'h3: acc = !sec;
            3'h4: acc = ok && !sec;
            // A secured protect erase becomes a chip erase for any block.
            3'h5: acc = ok || sec;
            default: acc = 1'b0;
        endcase
        acc = acc && exp_rdy;
        @(posedge hclk);
        cmd <= '{1'b1, fps_op_t'(op), blk};
        fail_req <= fail;
        #1;
        chk_flag("accept", acc, cmd_accept);
        chk_flag("refused", !acc, cmd_refused);
        @(posedge hclk);
        cmd.valid <= 1'b0;
        if (acc) begin
            #1;
            d = {25'h0, 1'b1, (sec ? 3'h3 : op), blk};
            chk_word("start", d, {25'h0, op_start});
            @(posedge hclk);
            cmd <= '{1'b1, OP_CHIP_ERASE, 3'h0};
            #1;
            chk_flag("busy accept", 1'b0, cmd_accept);
            @(posedge hclk);
            cmd.valid <= 1'b0;
            n = 0;
            while (op_done !== 1'b1 && n < 100) begin
                @(posedge hclk);
                #1;
                n++;
            end
            if (fail) exp_rdy = 1'b0;
            else if (op == 3'h4) exp_prot[blk] = 1'b1;
            else if (op == 3'h5) exp_prot = sec ? 6'h00 :
                exp_prot & (blk < 3'h4 ? 6'h30 : 6'h0F);
        end
        check_state;
    endtask : do_cmd

    task automatic stop_test;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        nv_bits = 6'($random(seed));
        exp_prot = nv_bits;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        check_state;
        bus(1'b1, 12'h018, 32'($random(seed)), d);
        bus(1'b0, 12'h018, 32'h0, d);
        chk_word("unmapped", 32'h0, d);
        for (int op = 0; op < 8; op++) begin
            do_cmd(3'(op), 3'($random(seed)), 1'b0);
        end
        do_cmd(3'h4, 3'h2, 1'b0);
        do_cmd(3'h4, 3'h5, 1'b0);
        do_cmd(3'h1, 3'h2, 1'b0);
        do_cmd(3'h5, 3'h1, 1'b0);
        bus(1'b1, SEC_REG_OFS, 32'h0, d);
        // The value write lands seventeen clocks after the key: too late.
        bus(1'b1, SEC_REG_OFS, UNLOCK_KEY, d);
        repeat (14) @(posedge hclk);
        bus(1'b1, SEC_REG_OFS, 32'h0, d);
        check_state;
        bus(1'b1, SEC_REG_OFS, UNLOCK_KEY, d);
        bus(1'b1, SEC_REG_OFS, 32'h0, d);
        exp_sec = 1'b0;
        for (int b = 0; b < 6; b++) begin
            do_cmd(3'h4, 3'(b), 1'b0);
        end
        bus(1'b1, SEC_REG_OFS, UNLOCK_KEY, d);
        bus(1'b1, SEC_REG_OFS, 32'h1, d);
        exp_sec = 1'b1;
        check_state;
        do_cmd(3'h1, 3'h0, 1'b0);
        do_cmd(3'h5, 3'h4, 1'b0);
        do_cmd(3'h4, 3'h3, 1'b1);
        @(posedge hclk);
        warm_resetn <= 1'b0;
        repeat (RST_MIN_CYC) @(posedge hclk);
        warm_resetn <= 1'b1;
        repeat (3) @(posedge hclk);
        #1;
        chk_flag("readable", 1'b0, readable);
        exp_rdy = 1'b1;
        check_state;
        repeat (RD_DLY) @(posedge hclk);
        #1;
        chk_flag("readable", 1'b1, readable);
        stop_test;
    end

    // A hang counts as one error and ends the run through stop_test.
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        stop_test;
    end
endmodule : flash_protect_security_bench
